// [inc/store_unit_consts.svh]
// Constants for the store execution unit
`ifndef STORE_UNIT_CONSTS_SVH
`define STORE_UNIT_CONSTS_SVH
`define SHORT_CONST_W 9
`define EXT_WORD_W 23
`define ADDR_W 32
`define PAIR_SHIFT 32
`define JUMP_READ_LATENCY 2
`define CREG_BASE_DEFAULT 32'hFFFF0000
`define CREG_MASK_DEFAULT 32'hFFFF0000
`endif

// [inc/store_unit_pkg.sv]
// Types shared by the store execution unit
package store_unit_pkg;
	typedef enum logic [2:0] {
		OP_STB,
		OP_STH,
		OP_STW,
		OP_STL,
		OP_STWL
	} store_op_t;
	typedef enum logic [2:0] {
		TRAP_NONE,
		TRAP_WATCH,
		TRAP_CTRL_VIOL,
		TRAP_CTRL_UNMAP,
		TRAP_XLATE,
		TRAP_ALIGN
	} trap_t;
endpackage

// [inc/store_check_if.sv]
// Address check interface between the store unit and its checker
`timescale 1ns/1ps
interface store_check_if;
	logic [31:0] addr;
	store_unit_pkg::store_op_t op;
	logic watch_hit;
	logic ctrl_space;
	logic ctrl_unmapped;
	logic xlate_fault;
	store_unit_pkg::trap_t trap;
	modport unit (output addr, op, watch_hit, ctrl_space, ctrl_unmapped, xlate_fault,
		input trap);
	modport checker_end (input addr, op, watch_hit, ctrl_space, ctrl_unmapped, xlate_fault,
		output trap);
endinterface

// [src/store_trap_check.sv]
// Ordered trap selection for one store operation
`timescale 1ns/1ps
`include "store_unit_consts.svh"
module store_trap_check
	import store_unit_pkg::*;
(
	store_check_if.checker_end chk
);
	// Natural alignment per access size
	function automatic logic misaligned(input store_op_t op, input logic [2:0] a);
		case (op)
			OP_STH: misaligned = a[0];
			OP_STW, OP_STWL: misaligned = |a[1:0];
			OP_STL: misaligned = |a[2:0];
			default: misaligned = 1'b0;
		endcase
	endfunction

	// First failing check wins: watchpoint, control space, translation, alignment
	always_comb begin
		chk.trap = TRAP_NONE;
		if (chk.watch_hit) begin
			chk.trap = TRAP_WATCH;
		end else if (chk.ctrl_space && chk.op != OP_STW) begin
			chk.trap = TRAP_CTRL_VIOL;
		end else if (chk.ctrl_space) begin
			// Word stores reach control registers and take their own checks
			if (misaligned(chk.op, chk.addr[2:0])) begin
				chk.trap = TRAP_ALIGN;
			end else if (chk.ctrl_unmapped) begin
				chk.trap = TRAP_CTRL_UNMAP;
			end
		end else if (chk.xlate_fault) begin
			chk.trap = TRAP_XLATE;
		end else if (misaligned(chk.op, chk.addr[2:0])) begin
			chk.trap = TRAP_ALIGN;
		end
	end
endmodule

// [src/store_unit.sv]
// Store execution stage of the load/store unit
`timescale 1ns/1ps
`include "store_unit_consts.svh"
module store_unit
	import store_unit_pkg::*;
#(
	parameter logic [31:0] CREG_BASE = `CREG_BASE_DEFAULT,
	parameter logic [31:0] CREG_MASK = `CREG_MASK_DEFAULT,
	parameter int JUMP_LATENCY = `JUMP_READ_LATENCY
) (
	input wire logic sys_clk_i,
	input wire logic sys_rst_i,
	input wire logic issue_i,
	input wire store_op_t op_i,
	input wire logic predicated_i,
	input wire logic [3:0] predicate_flag_reg_i,
	input wire logic [8:0] short_constant_operand_i,
	input wire logic ext_valid_i,
	input wire logic [22:0] ext_word_i,
	input wire logic [31:0] base_address_reg_i,
	input wire logic [31:0] store_value_reg_i,
	input wire logic [5:0] store_value_pair_i,
	input wire logic [31:0] pair_high_reg_i,
	input wire logic [2:0] success_flag_dest_i,
	input wire logic watch_hit_i,
	input wire logic ctrl_unmapped_i,
	input wire logic xlate_fault_i,
	input wire logic reserve_set_i,
	output logic mem_we_o,
	output logic creg_we_o,
	output logic [31:0] addr_o,
	output logic [63:0] wdata_o,
	output logic [7:0] byte_en_o,
	output logic trap_valid_o,
	output trap_t trap_o,
	output logic reservation_held_flag_o,
	output logic flag_we_o,
	output logic [2:0] flag_dest_o,
	output logic flag_value_o,
	output logic flag_jump_ready_o
);
	// ------------------------------------------------------------
	// Parameter checks
	// ------------------------------------------------------------
	// The jump delay line is eight stages deep, so longer waits cannot be served
	if (JUMP_LATENCY < 1 || JUMP_LATENCY > 8) begin : bad_jump_latency
		$error("JUMP_LATENCY out of range");
	end
	// The base must sit inside the decoded bits, or no address would ever match
	if ((CREG_BASE & ~CREG_MASK) != 32'h00000000) begin : bad_creg_window
		$error("CREG_BASE has bits outside CREG_MASK");
	end
	// An empty mask would turn every store into a control register access
	if (CREG_MASK == 32'h00000000) begin : bad_creg_mask
		$error("CREG_MASK selects no address bits");
	end


	// ------------------------------------------------------------
	// Address and data formation
	// ------------------------------------------------------------
	logic [31:0] offset;
	logic [31:0] eff_addr;
	logic [63:0] pair_data;
	logic active;
	logic ctrl_space;
	logic creg_hit;
	logic linked;
	store_check_if chk ();

	// Extension word takes the upper bits, else sign-extend the short constant
	assign offset = ext_valid_i ? {ext_word_i, short_constant_operand_i}
		: {{23{short_constant_operand_i[8]}}, short_constant_operand_i};
	// Linked store uses the base register alone; wrap keeps 32 bits
	assign eff_addr = (op_i == OP_STWL) ? base_address_reg_i
		: 32'(offset + base_address_reg_i);
	// Pair index zero reads as all-zero data
	assign pair_data = (store_value_pair_i == 6'h00) ? 64'h0000000000000000
		: {pair_high_reg_i, store_value_reg_i};
	// A zero predicate cancels the whole store, checks included
	assign active = issue_i && !(predicated_i && predicate_flag_reg_i == 4'h0);
	// Control space is one aligned window picked out by the mask bits
	assign ctrl_space = (eff_addr & CREG_MASK) == CREG_BASE;
	// Only a plain word store may reach the control register file
	assign creg_hit = ctrl_space && op_i == OP_STW;
	// Linked store-conditional decode, shared by the reservation and flag logic
	assign linked = op_i == OP_STWL;

	// The checker sees this cycle's address, so its verdict lines up with the op
	assign chk.addr = eff_addr;
	assign chk.op = op_i;
	assign chk.watch_hit = watch_hit_i;
	assign chk.ctrl_space = ctrl_space;
	assign chk.ctrl_unmapped = ctrl_unmapped_i;
	assign chk.xlate_fault = xlate_fault_i;

	store_trap_check u_check (
		.chk(chk)
	);

	// Byte lanes within the 64-bit write path
	function automatic logic [7:0] lanes(input store_op_t op, input logic [2:0] a);
		case (op)
			OP_STB: lanes = 8'(8'h01 << a);
			OP_STH: lanes = 8'(8'h03 << a);
			OP_STW, OP_STWL: lanes = 8'(8'h0F << a);
			OP_STL: lanes = 8'hFF;
			default: lanes = 8'h00;
		endcase
	endfunction

	// ------------------------------------------------------------
	// Reservation
	// ------------------------------------------------------------
	logic held;
	logic sampled;
	// The linked store sees the reservation as it stood before its own clear
	assign sampled = held;

	// Linked store clears the reservation whatever it finds; a new link wins
	always_ff @(posedge sys_clk_i) begin
		if (sys_rst_i) begin
			held <= 1'b0;
		end else if (reserve_set_i) begin
			held <= 1'b1;
		end else if (active && linked) begin
			held <= 1'b0;
		end
	end
	// Held flag leaves straight from its flip-flop
	assign reservation_held_flag_o = held;

	// ------------------------------------------------------------
	// Write and trap outputs
	// ------------------------------------------------------------
	logic allow;
	logic trapping;
	assign trapping = active && chk.trap != TRAP_NONE;
	// Write only on a clean check; linked store also needs the reservation
	assign allow = active && !trapping && (!linked || sampled);

	// Registered request to memory or the control register file
	always_ff @(posedge sys_clk_i) begin
		if (sys_rst_i) begin
			mem_we_o <= 1'b0;
			creg_we_o <= 1'b0;
			addr_o <= 32'h00000000;
			wdata_o <= 64'h0000000000000000;
			byte_en_o <= 8'h00;
		end else begin
			mem_we_o <= allow && !creg_hit;
			creg_we_o <= allow && creg_hit;
			// Address and data follow every cycle; only the strobes mark a store
			addr_o <= eff_addr;
			if (op_i == OP_STL) begin
				wdata_o <= pair_data;
			end else begin
				// Narrow data is copied to both halves so lanes 0 and 4 both start with its low byte
				wdata_o <= {store_value_reg_i, store_value_reg_i};
			end
			byte_en_o <= allow ? lanes(op_i, eff_addr[2:0]) : 8'h00;
		end
	end

	// Trap report, one cycle pulse
	always_ff @(posedge sys_clk_i) begin
		if (sys_rst_i) begin
			trap_valid_o <= 1'b0;
			trap_o <= TRAP_NONE;
		end else begin
			trap_valid_o <= trapping;
			// Code reads as none unless a trap is reported, so consumers need not gate it
			trap_o <= trapping ? chk.trap : TRAP_NONE;
		end
	end

	// ------------------------------------------------------------
	// Success flag write-back
	// ------------------------------------------------------------
	logic [7:0] jump_pipe;
	logic link_done;
	// A linked store that passed its checks owns a flag write, held or not
	assign link_done = active && linked && !trapping;
	// Flag goes out with the store; trapped linked stores write nothing
	always_ff @(posedge sys_clk_i) begin
		if (sys_rst_i) begin
			flag_we_o <= 1'b0;
			flag_dest_o <= 3'h0;
			flag_value_o <= 1'b0;
		end else begin
			flag_we_o <= link_done;
			flag_dest_o <= success_flag_dest_i;
			flag_value_o <= sampled;
		end
	end

	// Jumps may read the flag only after the fixed latency
	always_ff @(posedge sys_clk_i) begin
		if (sys_rst_i) begin
			jump_pipe <= 8'h00;
		end else begin
			jump_pipe <= {jump_pipe[6:0], link_done};
		end
	end
	// Tap picked by the parameter; deeper stages still shift but go unread at the default latency
	always_ff @(posedge sys_clk_i) begin
		if (sys_rst_i) begin
			flag_jump_ready_o <= 1'b0;
		end else begin
			flag_jump_ready_o <= jump_pipe[JUMP_LATENCY - 1];
		end
	end
endmodule

// [testbench/store_unit_checker.sv]
// Port assertions for the store unit
`timescale 1ns/1ps
module store_unit_checker
	import store_unit_pkg::*;
#(
	parameter int JUMP_LATENCY = 2
) (
	input wire logic sys_clk_i,
	input wire logic sys_rst_i,
	input wire logic issue_i,
	input wire store_op_t op_i,
	input wire logic predicated_i,
	input wire logic [3:0] predicate_flag_reg_i,
	input wire logic watch_hit_i,
	input wire logic reserve_set_i,
	input wire logic mem_we_o,
	input wire logic creg_we_o,
	input wire logic trap_valid_o,
	input wire trap_t trap_o,
	input wire logic reservation_held_flag_o,
	input wire logic flag_we_o,
	input wire logic flag_value_o,
	input wire logic flag_jump_ready_o
);
	// ----
	// Checks
	// ----
	// A zero predicate turns the op into a bubble
	wire logic go = issue_i && !(predicated_i && predicate_flag_reg_i == 4'h0);
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (sys_rst_i);
	skip_idle_a: assert property (!go
		|=> !mem_we_o && !creg_we_o && !trap_valid_o) else $error("idle store acted");
	trap_quiet_a: assert property (trap_valid_o
		|-> !mem_we_o && !creg_we_o && !flag_we_o) else $error("write beside trap");
	watch_first_a: assert property (go && watch_hit_i
		|=> trap_valid_o && trap_o == TRAP_WATCH) else $error("watch not first");
	res_clear_a: assert property (go && op_i == OP_STWL && !reserve_set_i
		|=> !reservation_held_flag_o) else $error("reservation kept");
	res_set_a: assert property (reserve_set_i
		|=> reservation_held_flag_o) else $error("reservation lost");
	flag_val_a: assert property (flag_we_o
		|-> flag_value_o == $past(reservation_held_flag_o)) else $error("bad flag");
	jump_wait_a: assert property (flag_we_o
		|-> ##JUMP_LATENCY flag_jump_ready_o) else $error("jump ready late");
	link_answer_a: assert property (go && op_i == OP_STWL
		|=> flag_we_o || trap_valid_o) else $error("no link answer");
endmodule

// [testbench/store_mem_model.sv]
// Far side: watchpoint, unmapped and translation answers
`timescale 1ns/1ps
module store_mem_model (
	input wire logic [31:0] ea_i,
	output logic watch_hit_o,
	output logic ctrl_unmapped_o,
	output logic xlate_fault_o
);
	// Fixed windows, so random traffic hits each fault now and then
	assign watch_hit_o = ea_i[11:8] == 4'hA;
	assign ctrl_unmapped_o = ea_i[7:4] == 4'hF;
	assign xlate_fault_o = ea_i[11:8] == 4'hB;
endmodule

// [testbench/tb.sv]
// Random stores against a reference model
`timescale 1ns/1ps
`include "store_unit_consts.svh"
module tb;
	import store_unit_pkg::*;
	logic sys_clk_i = 1'h0, sys_rst_i = 1'h1, issue_i = 1'h0, predicated_i = 1'h0;
	logic ext_valid_i = 1'h0, reserve_set_i = 1'h0, held = 1'h0, e_v = 1'h0, tk, ctl, mis;
	logic e_mem = 1'h0, e_creg = 1'h0, e_tv = 1'h0, e_fwe = 1'h0, e_fv;
	logic [7:0] e_be = 8'h00;
	logic [8:0] jq = 9'h000;
	logic [2:0] e_fd = 3'h0;
	store_op_t op_i = OP_STB;
	trap_t e_t, trap_o;
	logic [3:0] predicate_flag_reg_i = 4'h0;
	logic [8:0] short_constant_operand_i = 9'h000;
	logic [22:0] ext_word_i = 23'h000000;
	logic [31:0] base_address_reg_i = 32'h0, store_value_reg_i = 32'h0, pair_high_reg_i = 32'h0;
	logic [31:0] e_a, addr_o;
	logic [5:0] store_value_pair_i = 6'h00;
	logic [2:0] success_flag_dest_i = 3'h0, flag_dest_o;
	logic [63:0] e_wd, wdata_o;
	logic [7:0] byte_en_o;
	logic mem_we_o, creg_we_o, trap_valid_o, reservation_held_flag_o, flag_we_o, flag_value_o;
	logic flag_jump_ready_o, watch_hit_i, ctrl_unmapped_i, xlate_fault_i;
	int seed = 95650, errors = 0, total_checks = 0, sz;
	// Linked stores use the bare base; others add the offset
	wire logic [31:0] ea = op_i == OP_STWL ? base_address_reg_i : base_address_reg_i
		+ (ext_valid_i ? {ext_word_i, short_constant_operand_i}
		: {{23{short_constant_operand_i[8]}}, short_constant_operand_i});
	always #2.5 sys_clk_i = ~sys_clk_i;
	store_unit uut (
		.sys_clk_i(sys_clk_i),
		.sys_rst_i(sys_rst_i),
		.issue_i(issue_i),
		.op_i(op_i),
		.predicated_i(predicated_i),
		.predicate_flag_reg_i(predicate_flag_reg_i),
		.short_constant_operand_i(short_constant_operand_i),
		.ext_valid_i(ext_valid_i),
		.ext_word_i(ext_word_i),
		.base_address_reg_i(base_address_reg_i),
		.store_value_reg_i(store_value_reg_i),
		.store_value_pair_i(store_value_pair_i),
		.pair_high_reg_i(pair_high_reg_i),
		.success_flag_dest_i(success_flag_dest_i),
		.watch_hit_i(watch_hit_i),
		.ctrl_unmapped_i(ctrl_unmapped_i),
		.xlate_fault_i(xlate_fault_i),
		.reserve_set_i(reserve_set_i),
		.mem_we_o(mem_we_o),
		.creg_we_o(creg_we_o),
		.addr_o(addr_o),
		.wdata_o(wdata_o),
		.byte_en_o(byte_en_o),
		.trap_valid_o(trap_valid_o),
		.trap_o(trap_o),
		.reservation_held_flag_o(reservation_held_flag_o),
		.flag_we_o(flag_we_o),
		.flag_dest_o(flag_dest_o),
		.flag_value_o(flag_value_o),
		.flag_jump_ready_o(flag_jump_ready_o)
	);
	store_mem_model mem (.ea_i(ea), .watch_hit_o(watch_hit_i), .ctrl_unmapped_o(ctrl_unmapped_i),
		.xlate_fault_o(xlate_fault_i));
	task automatic chk(input string n, input logic [63:0] e, input logic [63:0] g);
		total_checks++;
		if (g !== e) begin
			errors++;
			$display("mismatch %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic wrap_up;
		$display("checks %0d mismatches %0d", total_checks, errors);
		if (errors == 0 && total_checks > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	// ----
	// Stimulus: one op per cycle, outputs checked the cycle after
	// ----
	initial begin
		repeat (6) @(posedge sys_clk_i);
		sys_rst_i <= 1'h0;
		repeat (4000) begin
			@(posedge sys_clk_i);
			issue_i <= 1'($random(seed));
			op_i <= store_op_t'($unsigned($random(seed)) % 5);
			// Predicate enable and flag value are drawn at random together; the value may be zero
			{predicated_i, predicate_flag_reg_i} <= 5'($random(seed));
			{ext_valid_i, store_value_pair_i} <= 7'($random(seed));
			{short_constant_operand_i, ext_word_i} <= $random(seed);
			base_address_reg_i <= $random(seed) | ($random(seed) % 4 == 0 ? 32'hFFFF0000 : 32'h0);
			{store_value_reg_i, pair_high_reg_i} <= {$random(seed), $random(seed)};
			{success_flag_dest_i, reserve_set_i} <= 4'($random(seed));
			@(negedge sys_clk_i);
			chk("mem_we", e_mem, mem_we_o);
			chk("creg_we", e_creg, creg_we_o);
			chk("trap_valid", e_tv, trap_valid_o);
			chk("flag_we", e_fwe, flag_we_o);
			chk("held", held, reservation_held_flag_o);
			chk("byte_en", e_be, byte_en_o);
			chk("jump_ready", jq[`JUMP_READ_LATENCY], flag_jump_ready_o);
			if (e_tv) chk("trap", e_t, trap_o);
			if (e_fwe) chk("flag", e_fv, flag_value_o);
			if (e_fwe) chk("flag_dest", e_fd, flag_dest_o);
			if (e_v) chk("addr", e_a, addr_o);
			if (e_v) chk("wdata", e_wd, wdata_o);
			// Reference model; control space is the top 64 KiB
			tk = issue_i && !(predicated_i && predicate_flag_reg_i == 4'h0);
			ctl = ea[31:16] == 16'hFFFF;
			sz = op_i == OP_STB ? 1 : op_i == OP_STH ? 2 : op_i == OP_STL ? 8 : 4;
			mis = (ea[2:0] & 3'(sz - 1)) != 3'h0;
			e_t = TRAP_NONE;
			if (watch_hit_i) e_t = TRAP_WATCH;
			else if (ctl && op_i != OP_STW) e_t = TRAP_CTRL_VIOL;
			else if (ctl) e_t = mis ? TRAP_ALIGN : ctrl_unmapped_i ? TRAP_CTRL_UNMAP : TRAP_NONE;
			else if (xlate_fault_i) e_t = TRAP_XLATE;
			else if (mis) e_t = TRAP_ALIGN;
			e_tv = tk && e_t != TRAP_NONE;
			e_creg = tk && !e_tv && ctl && op_i == OP_STW;
			e_mem = tk && !e_tv && !ctl && (op_i != OP_STWL || held);
			e_fwe = tk && !e_tv && op_i == OP_STWL;
			e_fv = held;
			e_v = issue_i;
			e_a = ea;
			e_wd = op_i != OP_STL ? {2{store_value_reg_i}} : store_value_pair_i == 6'h00 ? 64'h0
				: {pair_high_reg_i, store_value_reg_i};
			// Lanes cover the access size at its byte offset, none when nothing is written
			e_be = (e_mem || e_creg) ? 8'((8'hFF >> (8 - sz)) << ea[2:0]) : 8'h00;
			e_fd = success_flag_dest_i;
			jq = {jq[7:0], e_fwe};
			if (reserve_set_i) held = 1'h1;
			else if (tk && op_i == OP_STWL) held = 1'h0;
		end
		$display("random store run done");
		wrap_up();
	end
endmodule
bind store_unit store_unit_checker #(.JUMP_LATENCY(JUMP_LATENCY)) u_checker (
	.sys_clk_i(sys_clk_i),
	.sys_rst_i(sys_rst_i),
	.issue_i(issue_i),
	.op_i(op_i),
	.predicated_i(predicated_i),
	.predicate_flag_reg_i(predicate_flag_reg_i),
	.watch_hit_i(watch_hit_i),
	.reserve_set_i(reserve_set_i),
	.mem_we_o(mem_we_o),
	.creg_we_o(creg_we_o),
	.trap_valid_o(trap_valid_o),
	.trap_o(trap_o),
	.reservation_held_flag_o(reservation_held_flag_o),
	.flag_we_o(flag_we_o),
	.flag_value_o(flag_value_o),
	.flag_jump_ready_o(flag_jump_ready_o)
);
